//--- core/hbf_core.sv
// control and fault sequencing logic of a half-bridge gate driver
`timescale 1ns/10ps
`default_nettype none
`include "hbf_params.svh"
// ****************************************************************
// ****************************************************************
module hbf_core #(
  parameter int BOOST_CYC = `HBF_BOOST_CYC,
  parameter int BLANK_CYC = `HBF_BLANK_CYC,
  parameter int SSD_CYC = `HBF_SSD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire hbf_pkg::hbf_pair_t cmd_in,
  input wire hbf_pkg::hbf_pair_t desat_sense,
  input wire logic fault_clear_input,
  input wire logic vcc_uv,
  input wire logic sync_fault_line_i,
  output logic sync_fault_line_o,
  output logic sync_fault_line_oe,
  input wire logic fault_shutdown_line_i,
  output logic fault_shutdown_line_o,
  output logic fault_shutdown_line_oe,
  output hbf_pkg::hbf_drive_t top_gate_drive,
  output hbf_pkg::hbf_drive_t bottom_gate_drive
);
  import hbf_pkg::*;

  typedef enum logic [1:0] {HBF_RUN, HBF_SSD, HBF_LATCH} hbf_state_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one step of a down counter that parks at zero
  function automatic logic [`HBF_TMR_W-1:0] tmr_step(
    input logic [`HBF_TMR_W-1:0] cnt
  );
    if (cnt == '0) begin
      return '0;
    end
    return cnt - 1'b1;
  endfunction : tmr_step

  // a gate that goes from off to on at this edge
  function automatic logic turn_on(input logic nxt, input logic cur);
    return nxt && !cur;
  endfunction : turn_on

  localparam int ECHO_CYC = `HBF_ECHO_CYC;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int NS = `HBF_SYNC_W;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_r, s2_r, s3_r, in_r;
  always_comb begin
    raw[`HBF_IX_CMD_TOP] = cmd_in.top;
    raw[`HBF_IX_CMD_BOT] = cmd_in.bottom;
    raw[`HBF_IX_DSAT_TOP] = desat_sense.top;
    raw[`HBF_IX_DSAT_BOT] = desat_sense.bottom;
    raw[`HBF_IX_CLR] = fault_clear_input;
    raw[`HBF_IX_SYNC] = sync_fault_line_i;
    raw[`HBF_IX_FSD] = fault_shutdown_line_i;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= `HBF_SYNC_IDLE;
      s2_r <= `HBF_SYNC_IDLE;
      s3_r <= `HBF_SYNC_IDLE;
      in_r <= `HBF_SYNC_IDLE;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NS; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          in_r[i] <= s3_r[i];
        end
      end
    end
  end

  logic c_top, c_bot, d_top, d_bot, clr, sync_low, fsd_low;
  assign c_top = in_r[`HBF_IX_CMD_TOP];
  assign c_bot = in_r[`HBF_IX_CMD_BOT];
  assign d_top = in_r[`HBF_IX_DSAT_TOP];
  assign d_bot = in_r[`HBF_IX_DSAT_BOT];
  assign clr = in_r[`HBF_IX_CLR];
  assign sync_low = ~in_r[`HBF_IX_SYNC];
  assign fsd_low = ~in_r[`HBF_IX_FSD];

  // ****************************************************************
  // fault state machine
  // ****************************************************************
  hbf_state_t state_r;
  logic ssd_top_r;
  logic [`HBF_TMR_W-1:0] ssd_cnt_r;
  logic on_top_r, on_bot_r;
  logic [`HBF_TMR_W-1:0] blk_top_r, blk_bot_r;
  logic desat_top, desat_bot;
  logic ext_sd;
  logic own_sync, own_fsd;

  assign desat_top = on_top_r && (blk_top_r == '0) && d_top;
  assign desat_bot = on_bot_r && (blk_bot_r == '0) && d_bot;

  assign own_sync = (state_r == HBF_SSD);
  assign own_fsd = (state_r == HBF_LATCH) || vcc_uv;

  // ****************************************************************
  // own-drive echo masks
  // ****************************************************************
  // our own pull on a shared line comes back through the synchroniser
  // some cycles late; unmasked, releasing our own fault would read as
  // an external shutdown or a peer hold for those cycles
  logic [ECHO_CYC-1:0] fsd_echo_r, sync_echo_r;
  logic fsd_echo, sync_echo, peer_hold;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fsd_echo_r <= '0;
      sync_echo_r <= '0;
    end else begin
      fsd_echo_r <= {fsd_echo_r[ECHO_CYC-2:0], own_fsd};
      sync_echo_r <= {sync_echo_r[ECHO_CYC-2:0], own_sync};
    end
  end
  assign fsd_echo = |fsd_echo_r;
  assign sync_echo = |sync_echo_r;
  // limitation: a peer hold that starts just as our own ends is seen late
  assign peer_hold = sync_low && !sync_echo;

  // line low seen while we are not the one pulling it is external
  // masked during soft shutdown
  assign ext_sd = fsd_low && !own_fsd && !fsd_echo && (state_r != HBF_SSD);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= HBF_RUN;
      ssd_top_r <= 1'b0;
      ssd_cnt_r <= '0;
    end else begin
      case (state_r)
        HBF_RUN: begin
          if (desat_top || desat_bot) begin
            state_r <= HBF_SSD;
            ssd_top_r <= desat_top;
            ssd_cnt_r <= `HBF_TMR_W'(SSD_CYC - 1);
          end
        end
        HBF_SSD: begin
          if (ssd_cnt_r == '0) begin
            // clear already active skips the latch
            if (clr) begin
              state_r <= HBF_RUN;
            end else begin
              // fault latched at end of ssd
              state_r <= HBF_LATCH;
            end
          end else begin
            ssd_cnt_r <= ssd_cnt_r - 1'b1;
          end
        end
        HBF_LATCH: begin
          if (clr) begin
            state_r <= HBF_RUN;
          end
        end
        default: state_r <= HBF_RUN;
      endcase
    end
  end

  // ****************************************************************
  // gate command resolution
  // ****************************************************************
  logic want_top, want_bot, top_nxt, bot_nxt;
  always_comb begin
    want_top = c_top && !c_bot;
    want_bot = c_bot && !c_top;
    top_nxt = on_top_r;
    bot_nxt = on_bot_r;
    if (state_r == HBF_SSD) begin
      if (ssd_top_r) begin
        top_nxt = 1'b0;
      end else begin
        bot_nxt = 1'b0;
      end
    // hard shutdown; latched fault until clear, or shutdown line low or vcc_uv by level
    end else if (state_r == HBF_LATCH || ext_sd || vcc_uv) begin
      top_nxt = 1'b0;
      bot_nxt = 1'b0;
    // hold while sync pulled low by a peer
    end else if (!peer_hold) begin
      top_nxt = want_top;
      bot_nxt = want_bot;
    end
  end

  // ****************************************************************
  // gate state and turn-on timers
  // ****************************************************************
  logic [`HBF_TMR_W-1:0] bst_top_r, bst_bot_r;
  logic rise_top, rise_bot;
  assign rise_top = turn_on(top_nxt, on_top_r);
  assign rise_bot = turn_on(bot_nxt, on_bot_r);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      on_top_r <= 1'b0;
      on_bot_r <= 1'b0;
    end else begin
      on_top_r <= top_nxt;
      on_bot_r <= bot_nxt;
    end
  end

  // blanking interval
  // comparators are not trusted until the gate has had time to charge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blk_top_r <= '0;
      blk_bot_r <= '0;
    end else begin
      blk_top_r <= rise_top ? `HBF_TMR_W'(BLANK_CYC) : tmr_step(blk_top_r);
      blk_bot_r <= rise_bot ? `HBF_TMR_W'(BLANK_CYC) : tmr_step(blk_bot_r);
    end
  end

  // boost stage interval
  // boost drops at once on turn-off so a short pulse never leaves it armed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bst_top_r <= '0;
      bst_bot_r <= '0;
    end else begin
      if (rise_top) begin
        bst_top_r <= `HBF_TMR_W'(BOOST_CYC);
      end else if (!top_nxt) begin
        bst_top_r <= '0;
      end else begin
        bst_top_r <= tmr_step(bst_top_r);
      end
      if (rise_bot) begin
        bst_bot_r <= `HBF_TMR_W'(BOOST_CYC);
      end else if (!bot_nxt) begin
        bst_bot_r <= '0;
      end else begin
        bst_bot_r <= tmr_step(bst_bot_r);
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic ssd_top_act, ssd_bot_act;
  assign ssd_top_act = (state_r == HBF_SSD) && ssd_top_r;
  assign ssd_bot_act = (state_r == HBF_SSD) && !ssd_top_r;
  assign top_gate_drive.main_on = on_top_r;
  assign top_gate_drive.boost_on = on_top_r && (bst_top_r != '0);
  assign top_gate_drive.soft_off = ssd_top_act;
  assign bottom_gate_drive.main_on = on_bot_r;
  assign bottom_gate_drive.boost_on = on_bot_r && (bst_bot_r != '0);
  assign bottom_gate_drive.soft_off = ssd_bot_act;

  // sync low for every ssd
  // open drain: data tied low, enable pulls
  assign sync_fault_line_o = 1'b0;
  assign sync_fault_line_oe = own_sync;
  assign fault_shutdown_line_o = 1'b0;
  assign fault_shutdown_line_oe = own_fsd;
endmodule : hbf_core
`default_nettype wire

//--- inc/hbf_params.svh
// timing constants and fixed values for the half-bridge fault logic
`ifndef HBF_PARAMS_SVH
`define HBF_PARAMS_SVH

`define HBF_CLK_NS 10
// boost stage interval in ns, turn-on drive boost
`define HBF_BOOST_NS 500
`define HBF_BOOST_CYC ((`HBF_BOOST_NS) / (`HBF_CLK_NS))
// desaturation blanking after turn-on, in ns
`define HBF_BLANK_NS 3000
`define HBF_BLANK_CYC (((`HBF_BLANK_NS) + (`HBF_CLK_NS) - 1) / (`HBF_CLK_NS))
// soft shutdown duration in ns
`define HBF_SSD_NS 9250
`define HBF_SSD_CYC (((`HBF_SSD_NS) + (`HBF_CLK_NS) - 1) / (`HBF_CLK_NS))
`define HBF_TMR_W 12
// synchroniser lane positions
`define HBF_SYNC_W 7
`define HBF_IX_CMD_TOP 6
`define HBF_IX_CMD_BOT 5
`define HBF_IX_DSAT_TOP 4
`define HBF_IX_DSAT_BOT 3
`define HBF_IX_CLR 2
`define HBF_IX_SYNC 1
`define HBF_IX_FSD 0
// shared lines idle high, everything else idle low
`define HBF_SYNC_IDLE 7'h03
// cycles for which our own pull on a shared line may still echo back
`define HBF_ECHO_CYC 5

`endif

//--- inc/hbf_pkg.sv
// types shared by the half-bridge fault logic
package hbf_pkg;
  typedef struct packed {
    logic top;
    logic bottom;
  } hbf_pair_t;

  typedef struct packed {
    logic main_on;
    logic boost_on;
    logic soft_off;
  } hbf_drive_t;
endpackage : hbf_pkg

//--- tb/hbf_asserts.sv
// concurrent checks on the ports of the half-bridge fault logic
`timescale 1ns/10ps
`default_nettype none
module hbf_asserts #(
  parameter int BOOST_CYC = 2,
  parameter int SSD_CYC = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire hbf_pkg::hbf_pair_t cmd_in,
  input wire logic fault_clear_input,
  input wire logic sync_fault_line_i,
  input wire logic sync_fault_line_oe,
  input wire logic fault_shutdown_line_i,
  input wire logic fault_shutdown_line_oe,
  input wire hbf_pkg::hbf_drive_t top_gate_drive,
  input wire hbf_pkg::hbf_drive_t bottom_gate_drive
);
  import hbf_pkg::*;
  // ****************
  // port relations
  // ****************
  wire top_on = top_gate_drive.main_on;
  wire bot_on = bottom_gate_drive.main_on;
  wire so = sync_fault_line_oe;
  wire fo = fault_shutdown_line_oe;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // clear must stay put long enough to pass the synchroniser
  sequence clr_lo; !fault_clear_input [*6]; endsequence
  sequence clr_hi; fault_clear_input [*6]; endsequence
  AST_SHOOT: assert property ((cmd_in == 2'h3 && sync_fault_line_i) [*8] |-> !top_on && !bot_on)
    else $error("gate on with both commands");
  AST_SSD_LEN: assert property ($rose(so) |-> ##SSD_CYC $fell(so))
    else $error("soft shutdown length");
  AST_LATCH: assert property (clr_lo ##0 $fell(so) |-> fo)
    else $error("no fault after soft shutdown");
  AST_NO_FLT: assert property (clr_hi ##0 $fell(so) |-> !fo)
    else $error("fault despite clear");
  AST_KEEP: assert property (clr_lo ##0 fo |=> fo)
    else $error("fault dropped without clear");
  AST_EXT_OFF: assert property ((!fault_shutdown_line_i && !fo && !so) [*7] |-> !top_on && !bot_on)
    else $error("gate on under shutdown");
  AST_BOOST: assert property ($rose(top_on) |-> top_gate_drive.boost_on ##BOOST_CYC !top_gate_drive.boost_on)
    else $error("boost interval");
  AST_FREEZE: assert property ((!sync_fault_line_i && !so) [*6] |->
    ($stable(top_on) && $stable(bot_on)) || top_gate_drive.soft_off || bottom_gate_drive.soft_off)
    else $error("gate moved in hold");
endmodule : hbf_asserts
bind hbf_core hbf_asserts #(.BOOST_CYC(BOOST_CYC), .SSD_CYC(SSD_CYC)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .cmd_in(cmd_in),
  .fault_clear_input(fault_clear_input),
  .sync_fault_line_i(sync_fault_line_i),
  .sync_fault_line_oe(sync_fault_line_oe),
  .fault_shutdown_line_i(fault_shutdown_line_i),
  .fault_shutdown_line_oe(fault_shutdown_line_oe),
  .top_gate_drive(top_gate_drive),
  .bottom_gate_drive(bottom_gate_drive)
);
`default_nettype wire

//--- tb/hbf_core_bench.sv
// self-checking bench for the half-bridge fault logic
`timescale 1ns/10ps
`default_nettype none
module hbf_core_bench;
  import hbf_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic fault_clear_input = 1'b0;
  logic vcc_uv = 1'b0;
  logic hold_req = 1'b0;
  logic sd_req = 1'b0;
  hbf_pair_t cmd_in = 2'h0;
  hbf_pair_t desat_sense = 2'h0;
  logic sync_fault_line_i, sync_fault_line_o, sync_fault_line_oe;
  logic fault_shutdown_line_i, fault_shutdown_line_o, fault_shutdown_line_oe;
  hbf_drive_t top_gate_drive, bottom_gate_drive;
  int fails = 0;
  int total_checks = 0;
  // ****************
  // views: 0 gates, 1 sync and fault lines, 2 top main and boost,
  // 3 soft-off pair, 4 bottom boost and open-drain data
  // ****************
  wire [9:0] seen = {bottom_gate_drive.boost_on, sync_fault_line_o || fault_shutdown_line_o,
    top_gate_drive.soft_off, bottom_gate_drive.soft_off,
    top_gate_drive.main_on, top_gate_drive.boost_on, sync_fault_line_i,
    fault_shutdown_line_i, top_gate_drive.main_on, bottom_gate_drive.main_on};
  hbf_core #(.BOOST_CYC(2), .BLANK_CYC(4), .SSD_CYC(16)) DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .cmd_in(cmd_in),
    .desat_sense(desat_sense),
    .fault_clear_input(fault_clear_input),
    .vcc_uv(vcc_uv),
    .sync_fault_line_i(sync_fault_line_i),
    .sync_fault_line_o(sync_fault_line_o),
    .sync_fault_line_oe(sync_fault_line_oe),
    .fault_shutdown_line_i(fault_shutdown_line_i),
    .fault_shutdown_line_o(fault_shutdown_line_o),
    .fault_shutdown_line_oe(fault_shutdown_line_oe),
    .top_gate_drive(top_gate_drive),
    .bottom_gate_drive(bottom_gate_drive)
  );
  hbf_peer peer (
    .hold_req(hold_req),
    .sd_req(sd_req),
    .sync_fault_line_oe(sync_fault_line_oe),
    .fault_shutdown_line_oe(fault_shutdown_line_oe),
    .sync_fault_line_i(sync_fault_line_i),
    .fault_shutdown_line_i(fault_shutdown_line_i)
  );
  task final_report;
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  task wc(int n, int s, hbf_pair_t e);
    repeat (n) @(negedge clk_sys);
    total_checks++;
    if (seen[s*2+:2] !== e) begin
      fails++;
      $display("CHECK FAILED at %0t view %0d got %b", $time, s, seen[s*2+:2]);
    end
  endtask : wc
  task t_gate;
    cmd_in = 2'h3;
    wc(8, 0, 2'h0);
    cmd_in = 2'h2;
    wc(9, 2, 2'h2);
  endtask : t_gate
  task t_desat;
    desat_sense = 2'h1;
    wc(12, 1, 2'h3);
    desat_sense = 2'h2;
    wc(6, 0, 2'h0);
    wc(0, 3, 2'h2);
    cmd_in = 2'h1;
    wc(8, 1, 2'h1);
    wc(2, 0, 2'h0);
    wc(12, 1, 2'h2);
    desat_sense = 2'h0;
    wc(10, 0, 2'h0);
    fault_clear_input = 1'b1;
    wc(8, 0, 2'h1);
  endtask : t_desat
  task t_clr;
    repeat (6) @(negedge clk_sys);
    desat_sense = 2'h1;
    wc(6, 1, 2'h1);
    wc(0, 3, 2'h1);
    if (sync_fault_line_i === 1'b0) cmd_in = 2'h0;
    wc(20, 1, 2'h3);
    desat_sense = 2'h0;
    fault_clear_input = 1'b0;
  endtask : t_clr
  task t_hold;
    cmd_in = 2'h2;
    repeat (8) @(negedge clk_sys);
    hold_req = 1'b1;
    repeat (6) @(negedge clk_sys);
    cmd_in = 2'h1;
    wc(8, 0, 2'h2);
    hold_req = 1'b0;
    wc(8, 0, 2'h1);
    sd_req = 1'b1;
    wc(8, 0, 2'h0);
    fault_clear_input = 1'b1;
    wc(8, 0, 2'h0);
    sd_req = 1'b0;
    wc(8, 0, 2'h1);
    vcc_uv = 1'b1;
    wc(2, 0, 2'h0);
    wc(1, 1, 2'h2);
    vcc_uv = 1'b0;
    wc(1, 4, 2'h2);
    wc(7, 0, 2'h1);
  endtask : t_hold
  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    t_gate;
    t_desat;
    t_clr;
    t_hold;
    final_report;
  end
  // the run needs about 2 us, so ten times that means a hang
  initial begin
    #20000;
    fails++;
    final_report;
  end
endmodule : hbf_core_bench
`default_nettype wire

//--- tb/hbf_peer.sv
// peer drivers and controller pulling the shared open-drain lines
`timescale 1ns/10ps
`default_nettype none
module hbf_peer (
  input wire logic hold_req,
  input wire logic sd_req,
  input wire logic sync_fault_line_oe,
  input wire logic fault_shutdown_line_oe,
  output logic sync_fault_line_i,
  output logic fault_shutdown_line_i
);
  assign sync_fault_line_i = !(hold_req || sync_fault_line_oe);
  assign fault_shutdown_line_i = !(sd_req || fault_shutdown_line_oe);
endmodule : hbf_peer
`default_nettype wire
